// *** fbus_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbus_checker
	import fbus_pkg::*;
(
	input wire logic           aclk,
	input wire logic           aresetn,
	input wire logic           st_req_valid,
	input wire comm_state_type st_req,
	input wire comm_state_type cur_state,
	input wire logic           st_refused,
	input wire logic           sdo_valid,
	input wire logic           sdo_ready,
	input wire logic           sdo_resp_valid,
	input wire logic           sdo_abort,
	input wire logic           tpdo_valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_INIT_MUTE: assert property (
		cur_state == ST_INIT |-> !sdo_ready)
		else $error("mailbox open in init");
	AST_SKIP_UP: assert property (
		st_req_valid && int'(st_req) > int'(cur_state) + 1 |=> $stable(cur_state) && st_refused)
		else $error("skipped step accepted");
	AST_STEP_OK: assert property (
		st_req_valid && int'(st_req) <= int'(cur_state) + 1 |=> cur_state == $past(st_req) && !st_refused)
		else $error("legal step not taken");
	AST_REQ_PULSE: assert property (
		st_req_valid |=> !st_req_valid)
		else $error("state request held");
	AST_SDO_ANSWER: assert property (
		sdo_valid && sdo_ready |=> sdo_resp_valid)
		else $error("mailbox answer late");
	AST_RESP_ONE: assert property (
		sdo_resp_valid |=> !sdo_resp_valid)
		else $error("mailbox answer too long");
	AST_RESP_STATE: assert property (
		sdo_resp_valid |-> $past(cur_state) != ST_INIT)
		else $error("mailbox answer from init");
	AST_TPDO_GATE: assert property (
		tpdo_valid |-> $past(cur_state) inside {ST_SAFEOP, ST_OP})
		else $error("input data outside safe states");

	cover property (cur_state == ST_OP);
	cover property (sdo_resp_valid && sdo_abort);
	cover property (tpdo_valid);
endmodule
`default_nettype wire

// *** fbus_link.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fbus_link
	import fbus_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn
);
	logic           st_req_valid;
	comm_state_type st_req;
	logic           st_req_ready;
	comm_state_type cur_state;
	logic           st_refused;
	logic           sdo_valid;
	logic           sdo_write;
	logic [15:0]    sdo_index;
	logic [31:0]    sdo_wdata;
	logic           sdo_ready;
	logic           sdo_resp_valid;
	logic [31:0]    sdo_rdata;
	logic           sdo_abort;
	logic           rpdo_valid;
	logic [31:0]    rpdo_data;
	logic           tpdo_valid;
	logic [31:0]    tpdo_data;
	logic [15:0]    chip_alias;

	modport device (
		input  aclk, aresetn, st_req_valid, st_req, sdo_valid, sdo_write, sdo_index, sdo_wdata,
		       rpdo_valid, rpdo_data,
		output st_req_ready, cur_state, st_refused, sdo_ready, sdo_resp_valid, sdo_rdata,
		       sdo_abort, tpdo_valid, tpdo_data, chip_alias
	);
	modport master (
		input  aclk, aresetn, st_req_ready, cur_state, st_refused, sdo_ready, sdo_resp_valid,
		       sdo_rdata, sdo_abort, tpdo_valid, tpdo_data, chip_alias,
		output st_req_valid, st_req, sdo_valid, sdo_write, sdo_index, sdo_wdata, rpdo_valid,
		       rpdo_data
	);
endinterface
`default_nettype wire

// *** fbus_master.sv ***
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fbus_master
	import fbus_pkg::*;
(
	fbus_link.master         link,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	logic           bvalid_reg;
	logic [1:0]     bresp_reg;
	logic           rvalid_reg;
	logic [31:0]    rdata_reg;
	logic [1:0]     rresp_reg;
	logic [5:0]     cfg_reg;
	logic [15:0]    station_reg;
	logic           addr_set_reg;
	logic           order_err_reg;
	logic           st_valid_reg;
	comm_state_type st_target_reg;
	logic           sdo_valid_reg;
	logic           sdo_write_reg;
	logic [15:0]    sdo_index_reg;
	logic [31:0]    sdo_wdata_reg;
	logic [31:0]    sdo_rdata_reg;
	logic           sdo_busy_reg;
	logic           sdo_abort_reg;
	logic           rpdo_valid_reg;
	logic [31:0]    rpdo_data_reg;
	logic           rpdo_sent_reg;
	logic [31:0]    tpdo_reg;
	logic           wr_take;
	logic           rd_take;
	logic [1:0]     cur;
	logic [1:0]     tgt;
	logic           legal;
	logic           alias_done;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_take = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign s_axi_arready = rd_take;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
		end else if (wr_take) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (s_axi_awaddr > OFS_STATION || s_axi_awaddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'b00;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= 2'b00;
			case (s_axi_araddr)
				OFS_STATUS: begin
					rdata_reg <= {24'h00_0000, addr_set_reg, rpdo_sent_reg, sdo_abort_reg,
						sdo_busy_reg, order_err_reg, link.st_refused, cur};
				end
				OFS_CFG: begin
					rdata_reg <= {26'h000_0000, cfg_reg};
				end
				OFS_SDO_WDATA: begin
					rdata_reg <= sdo_wdata_reg;
				end
				OFS_SDO_RDATA: begin
					rdata_reg <= sdo_rdata_reg;
				end
				OFS_TPDO: begin
					rdata_reg <= tpdo_reg;
				end
				OFS_STATION: begin
					rdata_reg <= {16'h0000, station_reg};
				end
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= 2'b10;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			cfg_reg <= CFG_RST;
			sdo_wdata_reg <= 32'h0000_0000;
		end else if (wr_take && s_axi_awaddr == OFS_CFG) begin
			cfg_reg <= s_axi_wdata[5:0];
		end else if (wr_take && s_axi_awaddr == OFS_SDO_WDATA) begin
			sdo_wdata_reg <= s_axi_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State requests

	assign cur = 2'(link.cur_state);
	assign tgt = s_axi_wdata[1:0];
	always_comb begin
		legal = tgt <= cur;
		if (tgt == 2'(cur + 2'd1)) begin
			case (comm_state_type'(tgt))
				ST_PREOP: begin
					legal = addr_set_reg && cfg_reg[0];
				end
				ST_SAFEOP: begin
					legal = &cfg_reg[4:2];
				end
				ST_OP: begin
					legal = rpdo_sent_reg;
				end
				default: begin
					legal = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			st_valid_reg <= 1'b0;
			st_target_reg <= ST_INIT;
			order_err_reg <= 1'b0;
		end else if (wr_take && s_axi_awaddr == OFS_STATE_REQ && !st_valid_reg) begin
			st_valid_reg <= legal;
			st_target_reg <= comm_state_type'(tgt);
			order_err_reg <= !legal;
		end else if (link.st_req_ready) begin
			st_valid_reg <= 1'b0;
		end
	end

	assign link.st_req_valid = st_valid_reg;
	assign link.st_req = st_target_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Mailbox, process data, station address

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			sdo_valid_reg <= 1'b0;
			sdo_write_reg <= 1'b0;
			sdo_index_reg <= 16'h0000;
			sdo_busy_reg <= 1'b0;
			sdo_abort_reg <= 1'b0;
			sdo_rdata_reg <= 32'h0000_0000;
		end else if (wr_take && s_axi_awaddr == OFS_SDO_CMD && !sdo_busy_reg) begin
			sdo_valid_reg <= 1'b1;
			sdo_write_reg <= s_axi_wdata[16];
			sdo_index_reg <= s_axi_wdata[15:0];
			sdo_busy_reg <= 1'b1;
		end else begin
			if (link.sdo_ready) begin
				sdo_valid_reg <= 1'b0;
			end
			if (link.sdo_resp_valid) begin
				sdo_busy_reg <= 1'b0;
				sdo_abort_reg <= link.sdo_abort;
				sdo_rdata_reg <= link.sdo_rdata;
			end
		end
	end

	assign link.sdo_valid = sdo_valid_reg;
	assign link.sdo_write = sdo_write_reg;
	assign link.sdo_index = sdo_index_reg;
	assign link.sdo_wdata = sdo_wdata_reg;

	// copy chip alias after alias write
	assign alias_done = link.sdo_resp_valid && !link.sdo_abort && sdo_write_reg &&
		sdo_index_reg == IDX_ALIAS;

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			station_reg <= 16'h0000;
			addr_set_reg <= 1'b0;
		end else if (alias_done) begin
			station_reg <= link.chip_alias;
			addr_set_reg <= 1'b1;
		end else if (wr_take && s_axi_awaddr == OFS_STATION) begin
			station_reg <= cfg_reg[5] ? 16'(AUTO_ADDR_BASE + s_axi_wdata[15:0])
				: s_axi_wdata[15:0];
			addr_set_reg <= 1'b1;
		end
	end

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			rpdo_valid_reg <= 1'b0;
			rpdo_data_reg <= 32'h0000_0000;
			rpdo_sent_reg <= 1'b0;
			tpdo_reg <= 32'h0000_0000;
		end else begin
			rpdo_valid_reg <= wr_take && s_axi_awaddr == OFS_RPDO;
			if (wr_take && s_axi_awaddr == OFS_RPDO) begin
				rpdo_data_reg <= s_axi_wdata;
				rpdo_sent_reg <= cur >= 2'(ST_SAFEOP);
			end else if (cur < 2'(ST_SAFEOP)) begin
				rpdo_sent_reg <= 1'b0;
			end
			if (link.tpdo_valid) begin
				tpdo_reg <= link.tpdo_data;
			end
		end
	end

	assign link.rpdo_valid = rpdo_valid_reg;
	assign link.rpdo_data = rpdo_data_reg;
endmodule
`default_nettype wire

// *** fbus_pkg.sv ***
package fbus_pkg;

	typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} comm_state_type;
	typedef enum logic [2:0] {RNG_DATATYPE, RNG_COMM, RNG_RXMAP, RNG_TXMAP, RNG_MFR, RNG_PROFILE,
		RNG_RESERVED} od_range_type;

	// Dictionary index ranges
	localparam logic [15:0] COMM_LO     = 16'h1000;
	localparam logic [15:0] COMM_HI     = 16'h1FFF;
	localparam logic [15:0] RXMAP_LO    = 16'h1600;
	localparam logic [15:0] RXMAP_HI    = 16'h17FF;
	localparam logic [15:0] TXMAP_LO    = 16'h1A00;
	localparam logic [15:0] TXMAP_HI    = 16'h1BFF;
	localparam logic [15:0] MFR_LO      = 16'h2000;
	localparam logic [15:0] MFR_HI      = 16'h5FFF;
	localparam logic [15:0] PROFILE_LO  = 16'h6000;
	localparam logic [15:0] PROFILE_HI  = 16'h9FFF;
	localparam logic [15:0] RESERVED_LO = 16'hA000;

	// Object indices
	localparam logic [15:0] IDX_DEVICE_TYPE = 16'h1000;
	localparam logic [15:0] IDX_ERROR_FLAGS = 16'h1001;
	localparam logic [15:0] IDX_CTRL_MODE   = 16'h2000;
	localparam logic [15:0] IDX_WR_SAVE     = 16'h2005;
	localparam logic [15:0] IDX_ALIAS       = 16'h2008;
	localparam logic [15:0] IDX_MODE_SEL    = 16'h6060;

	// Values after reset
	localparam logic [15:0] CTRL_MODE_RST = 16'h0001;
	localparam logic [15:0] WR_SAVE_RST   = 16'h0000;
	localparam logic [15:0] ALIAS_RST     = 16'h0000;
	localparam logic [7:0]  MODE_SEL_RST  = 8'h08;
	localparam logic [3:0]  CTRL_MODE_BUS = 4'h1;

	// Field positions
	localparam int DIGIT_X_LSB = 0;
	localparam int DIGIT_Y_LSB = 4;
	localparam int ERR_GENERAL = 0;
	localparam int ERR_COMM    = 4;
	localparam int ERR_RSVD    = 6;

	// Operating mode codes
	localparam logic [7:0] MODE_PP  = 8'h01;
	localparam logic [7:0] MODE_PV  = 8'h03;
	localparam logic [7:0] MODE_PT  = 8'h04;
	localparam logic [7:0] MODE_HM  = 8'h06;
	localparam logic [7:0] MODE_CSP = 8'h08;
	localparam logic [7:0] MODE_CSV = 8'h09;
	localparam logic [7:0] MODE_CST = 8'h0A;

	// Controller register offsets
	localparam logic [7:0] OFS_STATE_REQ = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_CFG       = 8'h08;
	localparam logic [7:0] OFS_SDO_CMD   = 8'h0C;
	localparam logic [7:0] OFS_SDO_WDATA = 8'h10;
	localparam logic [7:0] OFS_SDO_RDATA = 8'h14;
	localparam logic [7:0] OFS_RPDO      = 8'h18;
	localparam logic [7:0] OFS_TPDO      = 8'h1C;
	localparam logic [7:0] OFS_STATION   = 8'h20;
	localparam logic [15:0] AUTO_ADDR_BASE = 16'h0001;
	localparam logic [5:0]  CFG_RST        = 6'h20;

endpackage

// *** fbus_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Decode dictionary indices by range
// - Device type: profile low, info high
// - Eight-bit error register, fixed bit meanings
// - Alias read-write, immediate, never process data
// - Master copies chip alias into station address
// - Master auto-numbers slaves along the chain
// - Digit X gates writes, Y gates saving
// - Values survive restart only when saved
// - Power up in bus control mode
// - Four communication states shared with master
// - Upward moves pass every state
// - Downward moves may skip states; master refuses Operational to Init
// - Init allows no application traffic
// - Master configures address, mailbox, clocks first
// - Pre-operational: mailbox only, no process data
// - Master sets mapping and channels first
// - Safe-operational: inputs sent, outputs ignored
// - Master sends valid outputs before Operational
// - Operational: both directions plus mailbox
// - Process data cyclic, mailbox reaches all
// - Seven drive operating modes supported
// - Receive and transmit mapping index ranges
module fbus_slave
	import fbus_pkg::*;
(
	fbus_link.device         link,
	input  wire logic [15:0] device_profile,
	input  wire logic [15:0] profile_info,
	input  wire logic [7:0]  fault_flags,
	input  wire logic        save_req,
	input  wire logic        restart_req,
	input  wire logic [31:0] tpdo_in,
	input  wire logic        tpdo_in_valid,
	output logic [31:0]      rpdo_out,
	output logic             rpdo_out_valid,
	output logic [7:0]       op_mode,
	output logic             bus_control,
	output logic [15:0]      station_alias,
	output comm_state_type   comm_state
);
	comm_state_type state_reg;
	logic           refused_reg;
	logic           comm_err_reg;
	logic [15:0]    ctrl_mode_reg;
	logic [15:0]    wr_save_reg;
	logic [15:0]    alias_reg;
	logic [7:0]     mode_sel_reg;
	logic           nv_valid_reg;
	logic [15:0]    nv_ctrl_reg;
	logic [15:0]    nv_wr_save_reg;
	logic [15:0]    nv_alias_reg;
	logic [7:0]     nv_mode_reg;
	logic           resp_valid_reg;
	logic [31:0]    rdata_reg;
	logic           abort_reg;
	logic [31:0]    tpdo_reg;
	logic           tpdo_valid_reg;
	logic [31:0]    rpdo_reg;
	logic           rpdo_valid_reg;
	od_range_type   range;
	logic           sdo_take;
	logic           up_step;
	logic           down_step;
	logic           req_ok;
	logic           writes_on;
	logic           wr_ok;
	logic [7:0]     error_flags;
	logic [31:0]    rd_next;
	logic           known;
	logic           mode_ok;

	od_range_decoder decoder (
		.index (link.sdo_index),
		.range (range)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Communication state machine

	assign up_step = 2'(link.st_req) == 2'(2'(state_reg) + 2'd1);
	assign down_step = 2'(link.st_req) <= 2'(state_reg);
	assign req_ok = up_step || down_step;
	assign link.st_req_ready = 1'b1;

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn || restart_req) begin
			state_reg <= ST_INIT;
		end else if (link.st_req_valid && req_ok) begin
			state_reg <= link.st_req;
		end
	end

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			refused_reg <= 1'b0;
			comm_err_reg <= 1'b0;
		end else if (link.st_req_valid) begin
			refused_reg <= !req_ok;
			comm_err_reg <= !req_ok;
		end
	end

	assign link.cur_state = state_reg;
	assign link.st_refused = refused_reg;
	assign comm_state = state_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Parameter objects and nonvolatile store

	assign writes_on = wr_save_reg[DIGIT_X_LSB +: 4] == 4'h0;
	assign mode_ok = link.sdo_wdata[7:0] inside {MODE_PP, MODE_PV, MODE_PT, MODE_HM, MODE_CSP,
		MODE_CSV, MODE_CST};
	assign sdo_take = link.sdo_valid && !resp_valid_reg && state_reg != ST_INIT;
	assign wr_ok = sdo_take && link.sdo_write && (writes_on || link.sdo_index == IDX_WR_SAVE);

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn || (restart_req && !nv_valid_reg)) begin
			ctrl_mode_reg <= CTRL_MODE_RST;
			wr_save_reg <= WR_SAVE_RST;
			alias_reg <= ALIAS_RST;
			mode_sel_reg <= MODE_SEL_RST;
		end else if (restart_req) begin
			ctrl_mode_reg <= nv_ctrl_reg;
			wr_save_reg <= nv_wr_save_reg;
			alias_reg <= nv_alias_reg;
			mode_sel_reg <= nv_mode_reg;
		end else if (wr_ok) begin
			case (link.sdo_index)
				IDX_CTRL_MODE: begin
					ctrl_mode_reg <= link.sdo_wdata[15:0];
				end
				IDX_WR_SAVE: begin
					wr_save_reg <= link.sdo_wdata[15:0];
				end
				IDX_ALIAS: begin
					alias_reg <= link.sdo_wdata[15:0];
				end
				IDX_MODE_SEL: begin
					if (mode_ok) begin
						mode_sel_reg <= link.sdo_wdata[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			nv_valid_reg <= 1'b0;
			nv_ctrl_reg <= CTRL_MODE_RST;
			nv_wr_save_reg <= WR_SAVE_RST;
			nv_alias_reg <= ALIAS_RST;
			nv_mode_reg <= MODE_SEL_RST;
		end else if (save_req && wr_save_reg[DIGIT_Y_LSB +: 4] == 4'h0) begin
			nv_valid_reg <= 1'b1;
			nv_ctrl_reg <= ctrl_mode_reg;
			nv_wr_save_reg <= wr_save_reg;
			nv_alias_reg <= alias_reg;
			nv_mode_reg <= mode_sel_reg;
		end
	end

	assign bus_control = ctrl_mode_reg[DIGIT_X_LSB +: 4] == CTRL_MODE_BUS;
	assign op_mode = mode_sel_reg;
	assign station_alias = alias_reg;
	assign link.chip_alias = alias_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Mailbox read path

	always_comb begin
		error_flags = fault_flags;
		error_flags[ERR_COMM] = fault_flags[ERR_COMM] | comm_err_reg;
		error_flags[ERR_RSVD] = 1'b0;
		error_flags[ERR_GENERAL] = |error_flags;
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		known = 1'b1;
		case (link.sdo_index)
			IDX_DEVICE_TYPE: begin
				rd_next = {profile_info, device_profile};
			end
			IDX_ERROR_FLAGS: begin
				rd_next = {24'h00_0000, error_flags};
			end
			IDX_CTRL_MODE: begin
				rd_next = {16'h0000, ctrl_mode_reg};
			end
			IDX_WR_SAVE: begin
				rd_next = {16'h0000, wr_save_reg};
			end
			IDX_ALIAS: begin
				rd_next = {16'h0000, alias_reg};
			end
			IDX_MODE_SEL: begin
				rd_next = {24'h00_0000, mode_sel_reg};
			end
			default: begin
				known = range == RNG_RXMAP || range == RNG_TXMAP;
			end
		endcase
		if (range == RNG_RESERVED) begin
			known = 1'b0;
		end
	end

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			resp_valid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			abort_reg <= 1'b0;
		end else begin
			resp_valid_reg <= sdo_take;
			if (sdo_take) begin
				rdata_reg <= rd_next;
				abort_reg <= !known || (link.sdo_write && (!wr_ok || range == RNG_COMM));
			end
		end
	end

	assign link.sdo_ready = !resp_valid_reg && state_reg != ST_INIT;
	assign link.sdo_resp_valid = resp_valid_reg;
	assign link.sdo_rdata = rdata_reg;
	assign link.sdo_abort = abort_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Process data

	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			tpdo_reg <= 32'h0000_0000;
			tpdo_valid_reg <= 1'b0;
		end else begin
			tpdo_valid_reg <= tpdo_in_valid && (state_reg == ST_SAFEOP || state_reg == ST_OP);
			if (tpdo_in_valid) begin
				tpdo_reg <= tpdo_in;
			end
		end
	end

	// outputs acted on only in Op
	always_ff @(posedge link.aclk) begin
		if (!link.aresetn) begin
			rpdo_reg <= 32'h0000_0000;
			rpdo_valid_reg <= 1'b0;
		end else begin
			rpdo_valid_reg <= link.rpdo_valid && state_reg == ST_OP;
			if (link.rpdo_valid && state_reg == ST_OP) begin
				rpdo_reg <= link.rpdo_data;
			end
		end
	end

	assign link.tpdo_valid = tpdo_valid_reg;
	assign link.tpdo_data = tpdo_reg;
	assign rpdo_out = rpdo_reg;
	assign rpdo_out_valid = rpdo_valid_reg;
endmodule
`default_nettype wire

// *** od_range_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module od_range_decoder
	import fbus_pkg::*;
(
	input  wire logic [15:0] index,
	output od_range_type     range
);
	always_comb begin
		if (index >= RESERVED_LO) begin
			range = RNG_RESERVED;
		end else if (index >= PROFILE_LO) begin
			range = RNG_PROFILE;
		end else if (index >= MFR_LO) begin
			range = RNG_MFR;
		end else if (index >= RXMAP_LO && index <= RXMAP_HI) begin
			range = RNG_RXMAP;
		end else if (index >= TXMAP_LO && index <= TXMAP_HI) begin
			range = RNG_TXMAP;
		end else if (index >= COMM_LO) begin
			range = RNG_COMM;
		end else begin
			range = RNG_DATATYPE;
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fbus_pkg::*;
;
	typedef struct {logic wr; logic [15:0] idx; logic [31:0] wd, ex; logic ab;} row_type;
	logic           aclk, aresetn, save_req, restart_req, tpdo_in_valid, rpdo_out_valid, ab;
	logic           bus_control, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic           s_axi_rvalid, s_axi_rready;
	logic [1:0]     s_axi_bresp, s_axi_rresp, rsp;
	logic [3:0]     s_axi_wstrb;
	logic [7:0]     s_axi_awaddr, s_axi_araddr, fault_flags, op_mode;
	logic [15:0]    device_profile, profile_info, station_alias;
	logic [31:0]    s_axi_wdata, s_axi_rdata, tpdo_in, rpdo_out, rd;
	comm_state_type comm_state;
	int             miscompares, n_compared, rcnt;
	logic [7:0]     modes [7] = '{MODE_PP, MODE_PV, MODE_PT, MODE_HM, MODE_CSP, MODE_CSV, MODE_CST};
	row_type        rows [13] = '{
		'{0, 16'h1000, 0, 32'h0002_0192, 0}, '{1, 16'h1000, 1, 0, 1},
		'{0, 16'h1001, 0, 32'h0000_0089, 0}, '{0, 16'h2000, 0, 32'h0000_0001, 0},
		'{0, 16'h2008, 0, 0, 0}, '{0, 16'h1600, 0, 0, 0}, '{0, 16'h1A00, 0, 0, 0},
		'{0, 16'hA000, 0, 0, 1}, '{0, 16'h3000, 0, 0, 1}, '{1, 16'h2008, 32'h0000_1234, 0, 0},
		'{1, 16'h2005, 1, 0, 0}, '{1, 16'h2008, 5, 0, 1}, '{1, 16'h2005, 0, 0, 0}};

	fbus_link fbus_link_i (.aclk(aclk), .aresetn(aresetn));
	fbus_master fbus_master_i (.link(fbus_link_i), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	fbus_slave fbus_slave_i (.link(fbus_link_i), .device_profile(device_profile),
		.profile_info(profile_info), .fault_flags(fault_flags), .save_req(save_req),
		.restart_req(restart_req), .tpdo_in(tpdo_in), .tpdo_in_valid(tpdo_in_valid),
		.rpdo_out(rpdo_out), .rpdo_out_valid(rpdo_out_valid), .op_mode(op_mode),
		.bus_control(bus_control), .station_alias(station_alias), .comm_state(comm_state));
	fbus_checker fbus_checker_i (.aclk(aclk), .aresetn(aresetn),
		.st_req_valid(fbus_link_i.st_req_valid), .st_req(fbus_link_i.st_req),
		.cur_state(fbus_link_i.cur_state), .st_refused(fbus_link_i.st_refused),
		.sdo_valid(fbus_link_i.sdo_valid), .sdo_ready(fbus_link_i.sdo_ready),
		.sdo_resp_valid(fbus_link_i.sdo_resp_valid), .sdo_abort(fbus_link_i.sdo_abort),
		.tpdo_valid(fbus_link_i.tpdo_valid));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (rpdo_out_valid === 1'b1)
			rcnt <= rcnt + 1;

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] ex);
		n_compared++;
		if (got !== ex) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 99) begin
			miscompares++;
			give_verdict();
		end
	endtask
	// Waits for ready or valid: 0 aw/w, 1 b, 2 ar, 3 r
	task automatic hs(input int k);
		int n;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (k == 0 ? s_axi_awready : k == 1 ? s_axi_bvalid : k == 2 ? s_axi_arready : s_axi_rvalid)
				break;
		end
		tmo(n);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		hs(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		hs(1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		hs(2);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		hs(3);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic sdo(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		int n;
		axw(OFS_SDO_WDATA, wd);
		axw(OFS_SDO_CMD, {15'h0000, wr, idx});
		for (n = 0; n < 99; n++) begin
			axr(OFS_STATUS);
			if (rd[4] === 1'b0)
				break;
		end
		tmo(n);
		ab = rd[5];
		axr(OFS_SDO_RDATA);
	endtask
	task automatic go(input comm_state_type s);
		axw(OFS_STATE_REQ, s);
		repeat (3) @(posedge aclk);
		chk(comm_state, s);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, save_req, restart_req, tpdo_in_valid, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, tpdo_in, miscompares, n_compared} = '0;
		s_axi_wstrb = 4'hF;
		device_profile = 16'h0192;
		profile_info = 16'h0002;
		fault_flags = 8'hC8;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(bus_control, 1'b1);
		chk(station_alias, 16'h0000);
		axw(OFS_STATE_REQ, ST_SAFEOP);
		axr(OFS_STATUS);
		chk(rd[3:0], 4'h8);
		axw(OFS_CFG, 32'h0000_003F);
		chk(rsp, 2'h0);
		axw(OFS_STATION, 32'h0000_0005);
		axr(OFS_STATION);
		chk(rd, 32'h0000_0006);
		go(ST_PREOP);
		foreach (rows[i]) begin
			sdo(rows[i].wr, rows[i].idx, rows[i].wd);
			chk(ab, rows[i].ab);
			if (!rows[i].wr && !rows[i].ab)
				chk(rd, rows[i].ex);
		end
		chk(station_alias, 16'h1234);
		axr(OFS_STATION);
		chk(rd, 32'h0000_1234);
		foreach (modes[i]) begin
			sdo(1'b1, IDX_MODE_SEL, modes[i]);
			chk(op_mode, modes[i]);
		end
		sdo(1'b1, IDX_MODE_SEL, 32'h0000_0002);
		chk(op_mode, MODE_CST);
		go(ST_SAFEOP);
		tpdo_in <= 32'hCAFE_0001;
		tpdo_in_valid <= 1'b1;
		@(posedge aclk);
		tpdo_in_valid <= 1'b0;
		repeat (3) @(posedge aclk);
		axr(OFS_TPDO);
		chk(rd, 32'hCAFE_0001);
		axw(OFS_RPDO, 32'h0000_0BAD);
		repeat (3) @(posedge aclk);
		chk(rcnt, 0);
		go(ST_OP);
		axw(OFS_RPDO, 32'h0000_1357);
		repeat (3) @(posedge aclk);
		chk(rcnt, 1);
		chk(rpdo_out, 32'h0000_1357);
		go(ST_PREOP);
		// Unmapped address answers with an error
		axr(8'hF0);
		chk(rsp, 2'h2);
		// Misaligned write answers with an error
		axw(8'h02, 32'h0000_0000);
		chk(rsp, 2'h2);
		save_req <= 1'b1;
		@(posedge aclk);
		save_req <= 1'b0;
		sdo(1'b1, IDX_ALIAS, 32'h0000_0055);
		restart_req <= 1'b1;
		@(posedge aclk);
		restart_req <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(station_alias, 16'h1234);
		chk(comm_state, ST_INIT);
		go(ST_PREOP);
		// Restart lands between the master's check and the slave's take
		restart_req <= 1'b1;
		axw(OFS_STATE_REQ, ST_SAFEOP);
		restart_req <= 1'b0;
		axr(OFS_STATUS);
		chk(rd[3:0], 4'h4);
		give_verdict();
	end
endmodule
`default_nettype wire
